/* hw/pbsc_ctrl.sv */
// Control logic of a pipelined burst static memory with no turnaround gaps.
//
// Function
// - Burst steps low two address bits only.
// - Load cycle ends any burst in progress.
// - Read/write ignored while bursting.
// - Access type latched on load cycle.
// - Write starts on selected unsuspended load low.
// - Byte selects pipelined two cycles to data.
// - Suspended edge ignores all synchronous inputs except reset.
// - Suspended edge holds every internal register unless reset is high.
// - Second chip select active high; need all.
// - Undriven burst order reads as high.
// - Burst counter wraps after fourth beat.
// - Read word driven two cycles after load.
// - Data outputs float after power-up until read.
`timescale 1ns/1ps
module pbsc_ctrl #(
   parameter int ADDR_W = pbsc_pkg::ADDR_W,
   parameter int DATA_W = pbsc_pkg::DATA_W,
   parameter int BYTES = pbsc_pkg::BYTES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic clock_suspend_n,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read_write_n,
   input wire logic advance_or_load,
   input wire logic chip_select_1_n,
   input wire logic chip_select_high,
   input wire logic chip_select_2_n,
   input wire logic [BYTES-1:0] byte_write_selects_n,
   input wire logic burst_order_select,
   input wire logic output_drive_n,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe
);
   // The clock-suspend pin is high to suspend, so active state runs when it is low.
   logic ce;
   assign ce = !clock_suspend_n;

   // The burst-order pin is pulled up inside the part, so an undriven pin is high.
   logic order_linear;
   assign order_linear = burst_order_select !== 1'b0;

   logic selected;
   assign selected = !chip_select_1_n && chip_select_high && !chip_select_2_n;

   logic load;
   assign load = ce && !advance_or_load;
   logic advance;
   assign advance = ce && advance_or_load;

   logic [ADDR_W-1:0] base_reg;
   logic [pbsc_pkg::BURST_W-1:0] count_reg;
   logic is_write_reg;
   logic active_reg;
   logic order_reg;

   function automatic logic [pbsc_pkg::BURST_W-1:0] burst_low(
      input logic [pbsc_pkg::BURST_W-1:0] start,
      input logic [pbsc_pkg::BURST_W-1:0] cnt,
      input logic lin);
      logic [pbsc_pkg::BURST_W-1:0] sum;
      sum = start + cnt;
      burst_low = lin ? sum : (start ^ cnt);
   endfunction

   // Burst state: load takes a new base, advance steps the counter, wrap is natural.
   always_ff @(posedge clk) begin
      if (reset) begin
         base_reg <= '0;
         count_reg <= pbsc_pkg::BURST_ZERO;
         is_write_reg <= 1'b0;
         active_reg <= 1'b0;
         order_reg <= 1'b1;
      end else if (load) begin
         base_reg <= address;
         count_reg <= pbsc_pkg::BURST_ZERO;
         is_write_reg <= !read_write_n;
         active_reg <= selected;
         order_reg <= order_linear;
      end else if (advance) begin
         count_reg <= count_reg + pbsc_pkg::BURST_ONE;
      end
   end

   // Current beat address and command. The burst itself is a live beat on advance.
   logic [ADDR_W-1:0] beat_addr;
   logic beat_valid;
   logic beat_write;
   always_comb begin
      if (load) begin
         beat_addr = address;
         beat_valid = selected;
         beat_write = !read_write_n;
      end else begin
         beat_addr = base_reg;
         beat_addr[pbsc_pkg::BURST_W-1:0] = burst_low(base_reg[pbsc_pkg::BURST_W-1:0],
            count_reg + pbsc_pkg::BURST_ONE, order_reg);
         beat_valid = advance && active_reg;
         beat_write = is_write_reg;
      end
   end

   // Two-stage command pipeline carries address, type and byte selects to data time.
   logic [ADDR_W-1:0] addr_pipe_reg [pbsc_pkg::PIPE_DEPTH];
   logic [BYTES-1:0] bw_pipe_reg [pbsc_pkg::PIPE_DEPTH];
   logic [pbsc_pkg::PIPE_DEPTH-1:0] vld_pipe_reg;
   logic [pbsc_pkg::PIPE_DEPTH-1:0] wr_pipe_reg;
   always_ff @(posedge clk) begin
      if (reset) begin
         vld_pipe_reg <= pbsc_pkg::PIPE_CLEAR;
         wr_pipe_reg <= pbsc_pkg::PIPE_CLEAR;
         addr_pipe_reg[0] <= '0;
         addr_pipe_reg[1] <= '0;
         bw_pipe_reg[0] <= '0;
         bw_pipe_reg[1] <= '0;
      end else if (ce) begin
         vld_pipe_reg <= {vld_pipe_reg[0], beat_valid};
         wr_pipe_reg <= {wr_pipe_reg[0], beat_write};
         addr_pipe_reg[0] <= beat_addr;
         addr_pipe_reg[1] <= addr_pipe_reg[0];
         bw_pipe_reg[0] <= ~byte_write_selects_n;
         bw_pipe_reg[1] <= bw_pipe_reg[0];
      end
   end

   // Stage two holds the word moving at the next active edge, for reads and writes alike.
   logic mem_wr;
   assign mem_wr = vld_pipe_reg[1] && wr_pipe_reg[1];
   logic [DATA_W-1:0] mem_q;
   pbsc_mem #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .BYTES(BYTES)) u_mem (
      .clk(clk),
      .ce(ce),
      .wr_en(mem_wr),
      .wr_bytes(bw_pipe_reg[1]),
      .addr(addr_pipe_reg[1]),
      .wr_data(data_in),
      .rd_data(mem_q)
   );

   // Read data is registered at the second active edge after the load, so it stands in n+2.
   logic rd_slot_reg;
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_slot_reg <= 1'b0;
      end else if (ce) begin
         rd_slot_reg <= vld_pipe_reg[1] && !wr_pipe_reg[1];
      end
   end
   assign data_out = mem_q;
   // Output enable is combinational because the drive enable pin is asynchronous.
   assign data_oe = rd_slot_reg && !output_drive_n;

   read_two_a: assert property (@(posedge clk) disable iff (reset)
      load && selected && read_write_n ##1 ce ##1 ce |=> rd_slot_reg)
      else $error("read pipeline broken");
   suspend_hold_a: assert property (@(posedge clk) disable iff (reset)
      !ce |=> $stable(count_reg) && $stable(vld_pipe_reg))
      else $error("state moved on suspended edge");
   burst_step_a: assert property (@(posedge clk) disable iff (reset)
      advance |=> count_reg == $past(count_reg) + pbsc_pkg::BURST_ONE)
      else $error("burst counter did not step");
   load_clear_a: assert property (@(posedge clk) disable iff (reset)
      load |=> count_reg == pbsc_pkg::BURST_ZERO)
      else $error("load did not end burst");
   type_latch_a: assert property (@(posedge clk) disable iff (reset)
      load |=> is_write_reg == !$past(read_write_n))
      else $error("access type not latched");
   type_keep_a: assert property (@(posedge clk) disable iff (reset)
      advance |=> $stable(is_write_reg))
      else $error("access type changed in burst");
   deselect_idle_a: assert property (@(posedge clk) disable iff (reset)
      load && !selected |=> !vld_pipe_reg[0])
      else $error("deselect started access");
   write_start_a: assert property (@(posedge clk) disable iff (reset)
      load && selected && !read_write_n |=> vld_pipe_reg[0] && wr_pipe_reg[0])
      else $error("write not started");
   bw_align_a: assert property (@(posedge clk) disable iff (reset)
      ce ##1 ce |=> bw_pipe_reg[1] == ~$past(byte_write_selects_n, 2))
      else $error("byte selects misaligned");
   drive_gate_a: assert property (@(posedge clk) disable iff (reset)
      data_oe |-> !output_drive_n && rd_slot_reg)
      else $error("data driven without enable");

   read_load_c: cover property (@(posedge clk) load && selected && read_write_n);
   write_burst_c: cover property (@(posedge clk) load && !read_write_n ##1 advance [*3]);
   suspend_c: cover property (@(posedge clk) vld_pipe_reg[0] && !ce);
   wrap_c: cover property (@(posedge clk) advance [*5]);
endmodule // pbsc_ctrl

/* hw/pbsc_mem.sv */
// Word memory with byte writes and a registered read port.
`timescale 1ns/1ps
module pbsc_mem #(
   parameter int ADDR_W = pbsc_pkg::ADDR_W,
   parameter int DATA_W = pbsc_pkg::DATA_W,
   parameter int BYTES = pbsc_pkg::BYTES
) (
   input wire logic clk,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [BYTES-1:0] wr_bytes,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wr_data,
   output logic [DATA_W-1:0] rd_data
);
   localparam int LANE = DATA_W / BYTES;
   logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];

   always_ff @(posedge clk) begin
      if (ce && wr_en) begin
         for (int b = 0; b < BYTES; b++) begin
            if (wr_bytes[b]) begin
               store[addr][b*LANE +: LANE] <= wr_data[b*LANE +: LANE];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (ce) begin
         rd_data <= store[addr];
      end
   end
endmodule // pbsc_mem

/* inc/pbsc_pkg.sv */
// Package of constants for the pipelined burst static memory control block.
package pbsc_pkg;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 36;
   localparam int BYTES = 4;
   localparam int BURST_W = 2;
   localparam logic [1:0] BURST_ONE = 2'h1;
   localparam logic [1:0] BURST_ZERO = 2'h0;
   localparam logic [1:0] PIPE_CLEAR = 2'h0;
   localparam int PIPE_DEPTH = 2;
endpackage

/* sim/pbsc_ctrl_tb.sv */
// Self-checking bench for the burst static memory control block.
`timescale 1ns/1ps
module pbsc_ctrl_tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic output_drive_n = 1'b0;
   logic clock_suspend_n, read_write_n, advance_or_load, chip_select_1_n;
   logic chip_select_high, chip_select_2_n, burst_order_select, data_oe;
   logic [pbsc_pkg::ADDR_W-1:0] address;
   logic [pbsc_pkg::BYTES-1:0] byte_write_selects_n;
   logic [pbsc_pkg::DATA_W-1:0] data_in, data_out;
   int n_fail = 0;
   int cmp_count = 0;
   always #5 clk = ~clk;
   pbsc_host host (.clk(clk), .clock_suspend_n(clock_suspend_n), .address(address),
      .read_write_n(read_write_n), .advance_or_load(advance_or_load),
      .chip_select_1_n(chip_select_1_n), .chip_select_high(chip_select_high),
      .chip_select_2_n(chip_select_2_n), .byte_write_selects_n(byte_write_selects_n),
      .burst_order_select(burst_order_select), .data_in(data_in));
   pbsc_ctrl dut (.clk(clk), .reset(reset), .clock_suspend_n(clock_suspend_n),
      .address(address), .read_write_n(read_write_n), .advance_or_load(advance_or_load),
      .chip_select_1_n(chip_select_1_n), .chip_select_high(chip_select_high),
      .chip_select_2_n(chip_select_2_n), .byte_write_selects_n(byte_write_selects_n),
      .burst_order_select(burst_order_select), .output_drive_n(output_drive_n),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
   function automatic logic [35:0] p(input logic [3:0] t, input logic [16:0] a);
      return {t, 15'h0, a};
   endfunction
   task automatic cmp_data(input logic [35:0] exp);
      cmp_count++;
      if (data_oe !== 1'b1 || data_out !== exp) begin
         n_fail++;
         $display("CHECK FAILED data_out expected %h seen %h", exp, data_out);
      end
   endtask
   task automatic cmp_oe(input logic exp);
      cmp_count++;
      if (data_oe !== exp) begin
         n_fail++;
         $display("CHECK FAILED data_oe expected %b seen %b", exp, data_oe);
      end
   endtask
   task automatic summarize;
      if (n_fail == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Second burst starts mid-block and masks its first beat to prove byte lanes.
   task automatic write_bursts;
      host.cmd(0, 0, 1, 0, 0, 17'h10, '1);
      host.cmd(1, 0, 1, 0, 0, 0, '1);
      host.cmd(1, 0, 1, 0, 0, 0, p(9, 17'h10));
      host.cmd(1, 0, 1, 0, 0, 0, p(9, 17'h11));
      host.order = 1'bz;
      host.cmd(0, 0, 1, 0, 4'hf, 17'h12, p(9, 17'h12));
      host.cmd(1, 0, 1, 0, 0, 0, p(9, 17'h13));
      host.cmd(1, 1, 1, 0, 0, 0, p(6, 17'h12));
      host.cmd(1, 1, 1, 0, 0, 0, p(6, 17'h13));
      host.cmd(0, 0, 0, 0, 0, 0, p(6, 17'h10));
      host.cmd(0, 0, 0, 0, 0, 0, p(6, 17'h11));
   endtask
   task automatic read_burst;
      host.order = 1'b0;
      host.cmd(0, 1, 1, 0, 0, 17'h11, '1);
      host.cmd(1, 0, 1, 0, 0, 0, '1);
      host.cmd(1, 0, 1, 0, 0, 0, '1);
      host.cmd(1, 0, 1, 0, 0, 0, '1);
      cmp_data(p(6, 17'h11));
      host.cmd(1, 0, 1, 0, 0, 0, '1);
      cmp_data(p(6, 17'h10));
      host.cmd(0, 0, 1, 1, 0, 17'h3, '0);
      cmp_data(p(6, 17'h13));
      host.cmd(1, 0, 1, 0, 0, 0, '1);
      cmp_data(p(6, 17'h13));
      host.cmd(0, 0, 0, 0, 0, 0, '1);
      cmp_data(p(9, 17'h12));
      host.cmd(0, 0, 0, 0, 0, 0, '1);
      cmp_data(p(6, 17'h11));
      output_drive_n = 1'b1;
      #1 cmp_oe(1'b0);
      output_drive_n = 1'b0;
      host.cmd(0, 0, 0, 0, 0, 0, '1);
      cmp_data(p(6, 17'h10));
      host.cmd(0, 0, 0, 0, 0, 0, '1);
      cmp_oe(1'b0);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1 reset = 1'b0;
      cmp_oe(1'b0);
      write_bursts();
      read_burst();
      summarize();
   end
   // The whole sequence needs about 30 cycles, so 200 cycles means a hang.
   initial begin
      #2000;
      n_fail++;
      summarize();
   end
endmodule // pbsc_ctrl_tb

/* sim/pbsc_host.sv */
// Memory controller model that drives the synchronous inputs of the control block except reset.
`timescale 1ns/1ps
module pbsc_host (
   input wire logic clk,
   output logic clock_suspend_n,
   output logic [pbsc_pkg::ADDR_W-1:0] address,
   output logic read_write_n,
   output logic advance_or_load,
   output logic chip_select_1_n,
   output logic chip_select_high,
   output logic chip_select_2_n,
   output logic [pbsc_pkg::BYTES-1:0] byte_write_selects_n,
   output logic burst_order_select,
   output logic [pbsc_pkg::DATA_W-1:0] data_in
);
   logic order = 1'b1;
   initial begin
      {clock_suspend_n, read_write_n, advance_or_load, chip_select_2_n} = 4'h0;
      {chip_select_1_n, chip_select_high, burst_order_select} = 3'h5;
      address = '0;
      byte_write_selects_n = '1;
      data_in = '0;
   end
   // Address and read/write are scrambled on suspended edges so that a leak shows up.
   task automatic cmd(input logic adv, rw, sel, sus, input logic [3:0] bw,
      input logic [16:0] a, input logic [35:0] d);
      @(posedge clk);
      #1;
      clock_suspend_n = sus;
      advance_or_load = adv;
      read_write_n = sus ? ~read_write_n : rw;
      chip_select_1_n = ~sel;
      chip_select_high = sel;
      byte_write_selects_n = bw;
      address = sus ? ~address : a;
      burst_order_select = order;
      data_in = d;
   endtask
endmodule // pbsc_host
